// ### servo_mode_map.svh
// register offsets, reset values and mode codes of the mode selector
`ifndef SERVO_MODE_MAP_SVH
`define SERVO_MODE_MAP_SVH

// byte offsets on the register bus
`define OFS_CONTROL_MODE 12'h000
`define OFS_LIMIT_CFG 12'h004
`define OFS_MAX_SPEED 12'h008
`define OFS_SPEED_TAB0 12'h010
`define OFS_SPEED_TAB1 12'h014
`define OFS_SPEED_TAB2 12'h018
`define OFS_TORQUE_TAB0 12'h020
`define OFS_TORQUE_TAB1 12'h024
`define OFS_TORQUE_TAB2 12'h028
`define OFS_STATUS 12'h030
`define POS_TAB_PAGE 4'h1
`define POS_TAB_PAGE_LSB 8

// reset values
`define RST_CONTROL_MODE 8'h00
`define RST_LIMIT_CFG 1'b0
`define RST_MAX_SPEED 16'h7FFF
`define RST_TABLE 16'h0000
`define RST_POS 32'h0000_0000

// field positions
`define LIM_SPEED_EN_BIT 0
`define POS_SEL_W 6

// control mode codes
`define CODE_PULSE_POS 8'h00
`define CODE_INDEX_POS 8'h01
`define CODE_SPEED 8'h02
`define CODE_TORQUE 8'h03
`define CODE_ZERO_SPEED 8'h04
`define CODE_ZERO_TORQUE 8'h05
`define CODE_PT_S 8'h06
`define CODE_PT_T 8'h07
`define CODE_PR_S 8'h08
`define CODE_PR_T 8'h09
`define CODE_S_T 8'h0A
`define CODE_PT_PR 8'h0D

// select patterns
`define SEL_SOURCE 2'b00
`define SEL_FIRST 2'b01
`define SEL_SECOND 2'b10
`define SEL_THIRD 2'b11

`endif

// ### servo_mode_pkg.sv
// types shared by the mode selector and its users
package servo_mode_pkg;

  typedef enum logic [1:0] {
    MODE_PULSE_POS,
    MODE_INDEX_POS,
    MODE_SPEED,
    MODE_TORQUE
  } ctrl_mode_e;

  // digital inputs from the machine controller
  typedef struct packed {
    logic servo_on;
    logic speed_pos_switch;
    logic speed_torque_switch;
    logic torque_pos_switch;
    logic [1:0] speed_select_inputs;
    logic [1:0] torque_select_inputs;
    logic [5:0] position_select_inputs;
    logic position_trigger;
  } din_s;

  // command bundle towards the control loops
  typedef struct packed {
    ctrl_mode_e mode;
    logic hold_stop;
    logic pos_valid;
    logic pulse_source;
    logic [31:0] pos_target;
    logic signed [15:0] speed_cmd;
    logic signed [15:0] torque_cmd;
    logic speed_limit_en;
    logic signed [15:0] speed_limit;
    logic [15:0] max_speed;
  } cmd_s;

endpackage

// ### servo_dual_mode_selector.sv
// control mode selection, command source choice and speed limit of the drive
//
// Notes on behaviour
// - codes 06,07,08 pair pulse pos+speed, pulse pos+torque, indexed pos+speed.
// - codes 09,0A,0D pair indexed+torque, speed+torque, pulse+indexed; input picks.
// - pairings never use the zero-command speed or torque variants.
// - pulse pairings take position from pulses, indexed pairings from the table.
// - speed/position switch on: speed mode, speed selects used, trigger ignored.
// - speed/position switch off: position mode, motor held until trigger rises.
// - trigger rising edge releases hold, starts move; in indexed mode also samples position selects, loads target.
// - speed/position switch back on returns to speed mode at once.
// - speed/torque switch on: torque mode from torque selects, speed selects only feed the speed limit.
// - speed/torque switch off: speed mode from speed selects, follows at once.
// - speed/torque switch back on resumes torque mode at once.
// - torque/position switch on: torque mode, trigger disabled.
// - torque/position switch off: position mode, held until trigger rises.
// - torque/position switch back on returns to torque mode at once.
// - torque selects both off: zero in zero-torque mode, else analog input.
// - torque selects act only while servo-on is active.
// - speed limit only in torque mode, sourced like the speed command.
// - speed limit active only when its enable bit is 1.
// - max speed setting caps motor speed in every mode.
// - torque selects 01,10,11 choose internal torque values one to three.
`timescale 1ns/1ps
`include "servo_mode_map.svh"

module servo_dual_mode_selector
  import servo_mode_pkg::*;
#(
  parameter int POS_ENTRIES = 64
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire din_s din_i,
  input wire logic signed [15:0] analog_speed_i,
  input wire logic signed [15:0] analog_torque_i,
  output cmd_s cmd_o
);

  localparam int POS_MAX = 1 << `POS_SEL_W;

  if (POS_ENTRIES < 1 || POS_ENTRIES > POS_MAX) begin : g_bad_entries
    $error("POS_ENTRIES must lie between 1 and 64");
  end

  if (`POS_SEL_W + 2 > `POS_TAB_PAGE_LSB) begin : g_bad_page
    $error("position index does not fit below the table page bits");
  end

  if (`OFS_STATUS >= (12'(`POS_TAB_PAGE) << `POS_TAB_PAGE_LSB)) begin : g_bad_map
    $error("register offsets overlap the position table page");
  end

  typedef logic [2:0] [15:0] tab3_t;
  typedef logic [POS_ENTRIES-1:0] [31:0] postab_t;

  typedef struct packed {
    din_s sync1;
    din_s sync2;
    logic trig_prev;
    logic [7:0] mode_code;
    logic lim_cfg;
    logic [15:0] max_speed;
    tab3_t speed_tab;
    tab3_t torque_tab;
    postab_t pos_tab;
    logic [`POS_SEL_W-1:0] pos_idx;
    cmd_s cmd;
    logic ack;
    logic [31:0] rdat;
  } state_s;

  state_s s_q;
  state_s s_d;

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic signed [15:0] cap_speed(input logic signed [15:0] v,
                                                   input logic [15:0] lim);
    logic signed [16:0] wide;
    logic signed [16:0] top;
    wide = 17'(v);
    top = $signed({1'b0, lim});
    if (wide > top) begin
      return 16'(top);
    end else if (wide < -top) begin
      return 16'(-top);
    end else begin
      return v;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // next state

  din_s din;
  logic trig_rise;
  logic dual;
  logic zero_speed;
  logic zero_torque;
  logic pos_mode;
  logic entry;
  ctrl_mode_e mode_new;
  logic [1:0] tsel;
  logic signed [15:0] speed_src;
  logic signed [15:0] torque_src;
  logic [`POS_SEL_W-1:0] widx;
  logic [31:0] merged;

  always_comb begin
    s_d = s_q;
    din = s_q.sync2;
    widx = wb_adr_i[`POS_SEL_W+1:2];
    merged = 32'h0000_0000;
    // input synchroniser
    // two stage sync
    s_d.sync1 = din_i;
    s_d.sync2 = s_q.sync1;
    s_d.trig_prev = s_q.sync2.position_trigger;
    trig_rise = din.position_trigger & ~s_q.trig_prev;

    dual = 1'b1;
    zero_speed = 1'b0;
    zero_torque = 1'b0;
    mode_new = MODE_PULSE_POS;
    case (s_q.mode_code)
      `CODE_PT_S: begin
        mode_new = din.speed_pos_switch ? MODE_SPEED : MODE_PULSE_POS;
      end
      `CODE_PT_T: begin
        mode_new = din.torque_pos_switch ? MODE_TORQUE : MODE_PULSE_POS;
      end
      `CODE_PR_S: begin
        mode_new = din.speed_pos_switch ? MODE_SPEED : MODE_INDEX_POS;
      end
      `CODE_PR_T: begin
        mode_new = din.torque_pos_switch ? MODE_TORQUE : MODE_INDEX_POS;
      end
      `CODE_S_T: begin
        mode_new = din.speed_torque_switch ? MODE_TORQUE : MODE_SPEED;
      end
      `CODE_PT_PR: begin
        mode_new = din.speed_pos_switch ? MODE_PULSE_POS : MODE_INDEX_POS;
      end
      `CODE_INDEX_POS: begin
        dual = 1'b0;
        mode_new = MODE_INDEX_POS;
      end
      `CODE_SPEED: begin
        dual = 1'b0;
        mode_new = MODE_SPEED;
      end
      `CODE_TORQUE: begin
        dual = 1'b0;
        mode_new = MODE_TORQUE;
      end
      `CODE_ZERO_SPEED: begin
        dual = 1'b0;
        zero_speed = 1'b1;
        mode_new = MODE_SPEED;
      end
      `CODE_ZERO_TORQUE: begin
        dual = 1'b0;
        zero_torque = 1'b1;
        mode_new = MODE_TORQUE;
      end
      default: begin
        dual = 1'b0;
        mode_new = MODE_PULSE_POS;
      end
    endcase
    if (dual) begin
      zero_speed = 1'b0;
      zero_torque = 1'b0;
    end

    s_d.cmd.mode = mode_new;
    pos_mode = (mode_new == MODE_PULSE_POS) || (mode_new == MODE_INDEX_POS);
    entry = dual && pos_mode && (s_q.cmd.mode != mode_new);
    s_d.cmd.pulse_source = (mode_new == MODE_PULSE_POS);

    if (!pos_mode) begin
      s_d.cmd.hold_stop = 1'b0;
      s_d.cmd.pos_valid = 1'b0;
    end else begin
      if (entry) begin
        s_d.cmd.hold_stop = 1'b1;
        s_d.cmd.pos_valid = 1'b0;
      end
      if (trig_rise) begin
        s_d.cmd.hold_stop = 1'b0;
        if (mode_new == MODE_INDEX_POS) begin
          s_d.cmd.pos_valid = 1'b1;
          s_d.pos_idx = din.position_select_inputs;
          if (32'(din.position_select_inputs) < POS_ENTRIES) begin
            s_d.cmd.pos_target = s_q.pos_tab[din.position_select_inputs];
          end else begin
            s_d.cmd.pos_target = `RST_POS;
          end
        end
      end
    end

    case (din.speed_select_inputs)
      `SEL_SOURCE: speed_src = zero_speed ? 16'sh0000 : analog_speed_i;
      `SEL_FIRST: speed_src = s_q.speed_tab[0];
      `SEL_SECOND: speed_src = s_q.speed_tab[1];
      default: speed_src = s_q.speed_tab[2];
    endcase
    tsel = din.servo_on ? din.torque_select_inputs : `SEL_SOURCE;
    case (tsel)
      `SEL_SOURCE: torque_src = zero_torque ? 16'sh0000 : analog_torque_i;
      `SEL_FIRST: torque_src = s_q.torque_tab[0];
      `SEL_SECOND: torque_src = s_q.torque_tab[1];
      default: torque_src = s_q.torque_tab[2];
    endcase

    s_d.cmd.speed_cmd = (mode_new == MODE_SPEED) ? cap_speed(speed_src, s_q.max_speed) : 16'sh0000;
    s_d.cmd.torque_cmd = (mode_new == MODE_TORQUE) ? torque_src : 16'sh0000;
    s_d.cmd.speed_limit_en = (mode_new == MODE_TORQUE) && s_q.lim_cfg;
    s_d.cmd.speed_limit = s_d.cmd.speed_limit_en ? cap_speed(speed_src, s_q.max_speed)
                                                 : $signed(s_q.max_speed);
    s_d.cmd.max_speed = s_q.max_speed;

    //////////////////////////////////////////////////////////////////////////////
    // wishbone slave, one wait state

    s_d.ack = 1'b0;
    if (wb_cyc_i && wb_stb_i && !s_q.ack) begin
      s_d.ack = 1'b1;
      s_d.rdat = 32'h0000_0000;
      if (wb_adr_i[11:`POS_TAB_PAGE_LSB] == `POS_TAB_PAGE) begin
        if (32'(widx) < POS_ENTRIES) begin
          s_d.rdat = s_q.pos_tab[widx];
          if (wb_we_i) begin
            s_d.pos_tab[widx] = lane_merge(s_q.pos_tab[widx], wb_dat_i, wb_sel_i);
          end
        end
      end else begin
        case (wb_adr_i)
          `OFS_CONTROL_MODE: begin
            s_d.rdat = {24'h000000, s_q.mode_code};
            merged = lane_merge({24'h000000, s_q.mode_code}, wb_dat_i, wb_sel_i);
            if (wb_we_i) begin
              s_d.mode_code = merged[7:0];
            end
          end
          `OFS_LIMIT_CFG: begin
            s_d.rdat[`LIM_SPEED_EN_BIT] = s_q.lim_cfg;
            if (wb_we_i && wb_sel_i[0]) begin
              s_d.lim_cfg = wb_dat_i[`LIM_SPEED_EN_BIT];
            end
          end
          `OFS_MAX_SPEED: begin
            s_d.rdat = {16'h0000, s_q.max_speed};
            merged = lane_merge({16'h0000, s_q.max_speed}, wb_dat_i, wb_sel_i);
            if (wb_we_i) begin
              s_d.max_speed = merged[15:0];
            end
          end
          `OFS_SPEED_TAB0, `OFS_SPEED_TAB1, `OFS_SPEED_TAB2: begin
            s_d.rdat = {16'h0000, s_q.speed_tab[wb_adr_i[3:2]]};
            merged = lane_merge(s_d.rdat, wb_dat_i, wb_sel_i);
            if (wb_we_i) begin
              s_d.speed_tab[wb_adr_i[3:2]] = merged[15:0];
            end
          end
          `OFS_TORQUE_TAB0, `OFS_TORQUE_TAB1, `OFS_TORQUE_TAB2: begin
            s_d.rdat = {16'h0000, s_q.torque_tab[wb_adr_i[3:2]]};
            merged = lane_merge(s_d.rdat, wb_dat_i, wb_sel_i);
            if (wb_we_i) begin
              s_d.torque_tab[wb_adr_i[3:2]] = merged[15:0];
            end
          end
          `OFS_STATUS: begin
            s_d.rdat = {20'h00000, s_q.pos_idx, s_q.cmd.speed_limit_en, s_q.cmd.pulse_source,
                        s_q.cmd.pos_valid, s_q.cmd.hold_stop, s_q.cmd.mode};
          end
          default: begin
            s_d.rdat = 32'h0000_0000;
          end
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.mode_code <= `RST_CONTROL_MODE;
      s_q.lim_cfg <= `RST_LIMIT_CFG;
      s_q.max_speed <= `RST_MAX_SPEED;
      s_q.cmd.max_speed <= `RST_MAX_SPEED;
      s_q.cmd.speed_limit <= $signed(`RST_MAX_SPEED);
      s_q.cmd.mode <= MODE_PULSE_POS;
      s_q.cmd.pulse_source <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign wb_ack_o = s_q.ack;
  assign wb_dat_o = s_q.rdat;
  assign cmd_o = s_q.cmd;

endmodule // servo_dual_mode_selector

// ### ctrl_model.sv
// machine controller model driving the digital input lines
`timescale 1ns/1ps
module ctrl_model
  import servo_mode_pkg::*;
(
  input wire logic clk_i,
  input wire din_s req_i,
  output din_s din_o
);
  // levels change only just after a clock edge
  always_ff @(posedge clk_i) begin
    din_o <= req_i;
  end
endmodule // ctrl_model

// ### servo_dual_mode_selector_asserts.sv
// port checker of the mode selector
`timescale 1ns/1ps
module mode_checker
  import servo_mode_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire din_s din_i,
  input wire logic signed [15:0] analog_torque_i,
  input wire cmd_s cmd_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic signed [16:0] cap;
  assign cap = {1'b0, cmd_o.max_speed};
  ////////////////////////////////////////
  sequence s_servo_off;
    (!din_i.servo_on) [*4];
  endsequence
  sequence s_torque_live;
    cmd_o.mode == MODE_TORQUE && cmd_o.torque_cmd != 16'sh0000;
  endsequence
  property p_servo_off;
    s_servo_off ##1 s_torque_live |-> cmd_o.torque_cmd == $past(analog_torque_i);
  endproperty
  property p_speed_cap;
    cmd_o.speed_cmd <= cap && cmd_o.speed_cmd >= -cap;
  endproperty
  property p_speed_zero;
    cmd_o.mode != MODE_SPEED |-> cmd_o.speed_cmd == 16'sh0000;
  endproperty
  property p_torque_zero;
    cmd_o.mode != MODE_TORQUE |-> cmd_o.torque_cmd == 16'sh0000;
  endproperty
  property p_limit_mode;
    cmd_o.speed_limit_en |-> cmd_o.mode == MODE_TORQUE;
  endproperty
  property p_limit_off;
    !cmd_o.speed_limit_en |-> cmd_o.speed_limit == cmd_o.max_speed;
  endproperty
  property p_hold_entry;
    $rose(cmd_o.hold_stop) |-> cmd_o.mode inside {MODE_PULSE_POS, MODE_INDEX_POS} && !cmd_o.pos_valid;
  endproperty
  property p_valid_release;
    cmd_o.pos_valid |-> !cmd_o.hold_stop;
  endproperty
  property p_target_trig;
    $changed(cmd_o.pos_target) |-> $past(din_i.position_trigger, 3);
  endproperty
  property p_index_src;
    cmd_o.mode == MODE_INDEX_POS |-> !cmd_o.pulse_source;
  endproperty
  ////////////////////////////////////////
  a_servo_off: assert property (p_servo_off)
    else $error("torque select used while servo off");
  a_speed_cap: assert property (p_speed_cap)
    else $error("speed command beyond max speed");
  a_speed_zero: assert property (p_speed_zero)
    else $error("speed command outside speed mode");
  a_torque_zero: assert property (p_torque_zero)
    else $error("torque command outside torque mode");
  a_limit_mode: assert property (p_limit_mode)
    else $error("speed limit outside torque mode");
  a_limit_off: assert property (p_limit_off)
    else $error("disabled speed limit not at max speed");
  a_hold_entry: assert property (p_hold_entry)
    else $error("hold outside position mode");
  a_valid_release: assert property (p_valid_release)
    else $error("valid target while held");
  a_target_trig: assert property (p_target_trig)
    else $error("target changed without trigger");
  a_index_src: assert property (p_index_src)
    else $error("indexed mode using pulse source");
endmodule // mode_checker

bind servo_dual_mode_selector mode_checker chk (.clk_i, .rst_i, .din_i, .analog_torque_i, .cmd_o);

// ### servo_dual_mode_selector_test.sv
// self-checking bench of the mode selector
`timescale 1ns/1ps
`include "servo_mode_map.svh"
module servo_dual_mode_selector_test
  import servo_mode_pkg::*;
;
  typedef struct packed {logic [7:0] code; logic [1:0] sw; logic on; logic [1:0] m;} row_s;
  row_s rows [12] = '{'{8'h06, 2'd0, 1'b1, MODE_SPEED}, '{8'h06, 2'd0, 1'b0, MODE_PULSE_POS},
    '{8'h07, 2'd2, 1'b1, MODE_TORQUE}, '{8'h07, 2'd2, 1'b0, MODE_PULSE_POS},
    '{8'h08, 2'd0, 1'b1, MODE_SPEED}, '{8'h08, 2'd0, 1'b0, MODE_INDEX_POS},
    '{8'h09, 2'd2, 1'b1, MODE_TORQUE}, '{8'h09, 2'd2, 1'b0, MODE_INDEX_POS},
    '{8'h0A, 2'd1, 1'b1, MODE_TORQUE}, '{8'h0A, 2'd1, 1'b0, MODE_SPEED},
    '{8'h0D, 2'd0, 1'b1, MODE_PULSE_POS}, '{8'h0D, 2'd0, 1'b0, MODE_INDEX_POS}};
  logic clk_i;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [31:0] dat = 32'h0;
  logic [31:0] rdata;
  logic ack;
  cmd_s cmd;
  din_s din;
  din_s req = '{servo_on: 1'b1, default: '0};
  logic signed [15:0] asp = 16'sh0123;
  logic signed [15:0] atq = 16'sh0345;
  logic [1:0] em;
  int n_errors = 0;
  int cmp_count = 0;
  int ticks = 0;
  servo_dual_mode_selector #(.POS_ENTRIES(4)) DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdata),
    .wb_ack_o(ack), .din_i(din), .analog_speed_i(asp), .analog_torque_i(atq), .cmd_o(cmd));
  ctrl_model ctl (.clk_i(clk_i), .req_i(req), .din_o(din));
  ////////////////////////////////////////
  task automatic conclude();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdata;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string nm);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(nm, e, q);
  endtask
  task automatic set_sw(input logic [1:0] s, input logic v);
    @(posedge clk_i);
    if (s == 2'd0) req.speed_pos_switch <= v;
    else if (s == 2'd1) req.speed_torque_switch <= v;
    else req.torque_pos_switch <= v;
  endtask
  task automatic trig(input logic [5:0] s);
    @(posedge clk_i);
    req.position_select_inputs <= s;
    req.position_trigger <= 1'b1;
    wt(4);
    req.position_trigger <= 1'b0;
    wt(8);
  endtask
  ////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    ticks++;
    if (ticks == 20000) begin
      n_errors++;
      conclude();
    end
  end
  initial begin
    wt(4);
    rst_i <= 1'b0;
    rdc(`OFS_MAX_SPEED, 32'h0000_7FFF, "max_speed");
    rdc(`OFS_CONTROL_MODE, 32'h0, "mode_code");
    foreach (rows[i]) begin
      wr(`OFS_CONTROL_MODE, {24'h0, rows[i].code});
      set_sw(rows[i].sw, !rows[i].on);
      wt(8);
      set_sw(rows[i].sw, rows[i].on);
      wt(8);
      em = rows[i].m;
      chk("mode", em, cmd.mode);
      if (rows[i].code != 8'h0D) chk("hold", em < 2'd2, cmd.hold_stop);
      if (em < 2'd2) chk("pulse_src", em == MODE_PULSE_POS, cmd.pulse_source);
      chk("speed", em == MODE_SPEED ? asp : 16'sh0, cmd.speed_cmd);
      chk("torque", em == MODE_TORQUE ? atq : 16'sh0, cmd.torque_cmd);
    end
    wr(12'h108, 32'h0000_1234);
    wr(`OFS_CONTROL_MODE, {24'h0, `CODE_PR_S});
    set_sw(2'd0, 1'b1);
    wt(8);
    set_sw(2'd0, 1'b0);
    wt(8);
    chk("valid", 32'h0, cmd.pos_valid);
    trig(6'd2);
    chk("hold", 32'h0, cmd.hold_stop);
    chk("valid", 32'h1, cmd.pos_valid);
    chk("target", 32'h1234, cmd.pos_target);
    rdc(`OFS_STATUS, 32'h0000_0089, "status");
    rdc(12'h108, 32'h0000_1234, "pos_entry");
    set_sw(2'd0, 1'b1);
    wt(8);
    chk("mode", MODE_SPEED, cmd.mode);
    trig(6'd3);
    chk("target", 32'h1234, cmd.pos_target);
    for (int k = 1; k < 4; k++) begin
      wr(12'(`OFS_SPEED_TAB0 + 4 * (k - 1)), 32'h200 + k);
      wr(12'(`OFS_TORQUE_TAB0 + 4 * (k - 1)), 32'h100 + k);
    end
    wr(`OFS_LIMIT_CFG, 32'h1);
    wr(`OFS_CONTROL_MODE, {24'h0, `CODE_S_T});
    set_sw(2'd1, 1'b1);
    for (int k = 1; k < 4; k++) begin
      @(posedge clk_i);
      req.torque_select_inputs <= 2'(k);
      req.speed_select_inputs <= 2'(k);
      wt(8);
      chk("torque", 32'h100 + k, cmd.torque_cmd);
      chk("limit", 32'h200 + k, cmd.speed_limit);
      chk("limit_en", 32'h1, cmd.speed_limit_en);
    end
    @(posedge clk_i);
    req.servo_on <= 1'b0;
    req.torque_select_inputs <= 2'd1;
    wt(8);
    chk("torque", atq, cmd.torque_cmd);
    req.servo_on <= 1'b1;
    set_sw(2'd1, 1'b0);
    for (int k = 1; k < 4; k++) begin
      @(posedge clk_i);
      req.speed_select_inputs <= 2'(k);
      wt(8);
      chk("speed", 32'h200 + k, cmd.speed_cmd);
      chk("limit_en", 32'h0, cmd.speed_limit_en);
    end
    wr(`OFS_LIMIT_CFG, 32'h0);
    set_sw(2'd1, 1'b1);
    wt(8);
    chk("limit_en", 32'h0, cmd.speed_limit_en);
    chk("limit", 32'h7FFF, cmd.speed_limit);
    set_sw(2'd1, 1'b0);
    req.speed_select_inputs <= 2'd0;
    asp <= -16'sh0200;
    wr(`OFS_MAX_SPEED, 32'h100);
    wt(8);
    chk("speed", 32'hFFFF_FF00, cmd.speed_cmd);
    rdc(`OFS_MAX_SPEED, 32'h100, "max_speed");
    rdc(12'hFFC, 32'h0, "unmapped");
    wr(`OFS_CONTROL_MODE, {24'h0, `CODE_ZERO_TORQUE});
    req.torque_select_inputs <= 2'd0;
    wt(8);
    chk("mode", MODE_TORQUE, cmd.mode);
    chk("torque", 32'h0, cmd.torque_cmd);
    wr(`OFS_CONTROL_MODE, {24'h0, `CODE_ZERO_SPEED});
    wt(4);
    chk("mode", MODE_SPEED, cmd.mode);
    chk("speed", 32'h0, cmd.speed_cmd);
    wr(`OFS_CONTROL_MODE, {24'h0, `CODE_SPEED});
    wt(4);
    chk("speed", 32'hFFFF_FF00, cmd.speed_cmd);
    wr(`OFS_CONTROL_MODE, {24'h0, `CODE_TORQUE});
    wt(4);
    chk("torque", atq, cmd.torque_cmd);
    wr(`OFS_LIMIT_CFG, 32'h1);
    rst_i <= 1'b1;
    wt(2);
    rst_i <= 1'b0;
    rdc(`OFS_LIMIT_CFG, 32'h0, "limit_cfg");
    rdc(`OFS_MAX_SPEED, 32'h0000_7FFF, "max_speed");
    chk("mode", MODE_PULSE_POS, cmd.mode);
    conclude();
  end
endmodule // servo_dual_mode_selector_test
